// ---- verilog/io_expander_regs.svh ----
// Register offsets, field positions and timing constants of the I/O expander
`ifndef IO_EXPANDER_REGS_SVH
`define IO_EXPANDER_REGS_SVH

// ----------------------------------------
// Register pointers (command byte)
// ----------------------------------------
`define REG_DIR       3'h0
`define REG_OTYPE     3'h1
`define REG_INTEN     3'h2
`define REG_FANCFG    3'h3
`define REG_STATUS    3'h4
`define REG_DATA      3'h5
`define REG_FANSPD    3'h6

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define FANCFG_EN_BIT 0
`define UPPER_LO      4
`define REG_RST       8'h00
`define LINK_IDLE     2'h3
`define FANSPD_RST    3'h0

// ----------------------------------------
// Link addressing
// ----------------------------------------
`define TGT_ADDR_HI   4'h4
`define ALERT_RESP    7'h0c
`define BYTE_BITS     4'h8

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_MHZ       50
`define SPINUP_US     2000
`define TMR_W         20

`endif

// ---- verilog/io_expander_pkg.sv ----
// Types shared by the I/O expander design
package io_expander_pkg;

    typedef enum logic [3:0] {
        LK_IDLE,
        LK_ADDR,
        LK_ACK_ADDR,
        LK_CMD,
        LK_ACK_WR,
        LK_WDATA,
        LK_RDATA,
        LK_RACK
    } link_state_e;

    typedef enum logic [1:0] {
        FAN_OFF,
        FAN_SPINUP,
        FAN_RUN
    } fan_state_e;

endpackage

// ---- verilog/smbus_io_expander_fan_ctl.sv ----
// Two-wire target I/O expander with fan speed control and change alert
`timescale 1ns/10ps
`include "io_expander_regs.svh"

module smbus_io_expander_fan_ctl
    import io_expander_pkg::*;
#(
    parameter int SPINUP_CYC = `SPINUP_US * `CLK_MHZ
) (
    // Clock and reset
    input  wire logic       core_clk,
    input  wire logic       rst,
    // Serial link
    input  wire logic       bus_clk_in,
    input  wire logic       bus_data_in,
    output logic            bus_data_out,
    output logic            bus_data_oe_n,
    // Address straps
    input  wire logic [2:0] target_addr_select,
    // Alert, open drain
    output logic            alert_out,
    output logic            alert_oe_n,
    // Parallel lines
    input  wire logic [7:0] line_in,
    output logic [7:0]      line_out,
    output logic [7:0]      line_oe_n
);

    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    logic [12:0] meta_r;
    logic [12:0] sync_r;
    logic        clk_d_r;
    logic        dat_d_r;
    logic        clk_s;
    logic        dat_s;
    logic [2:0]  asel_s;
    logic [7:0]  pin_s;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            meta_r  <= {11'h000, `LINK_IDLE};
            sync_r  <= {11'h000, `LINK_IDLE};
            clk_d_r <= 1'b1;
            dat_d_r <= 1'b1;
        end else begin
            meta_r  <= {target_addr_select, line_in, bus_clk_in, bus_data_in};
            sync_r  <= meta_r;
            clk_d_r <= sync_r[1];
            dat_d_r <= sync_r[0];
        end
    end

    assign clk_s  = sync_r[1];
    assign dat_s  = sync_r[0];
    assign pin_s  = sync_r[9:2];
    assign asel_s = sync_r[12:10];

    logic clk_rise;
    logic clk_fall;
    logic start_ev;
    logic stop_ev;

    // Start and stop only while the clock stays high
    assign clk_rise = clk_s & ~clk_d_r;
    assign clk_fall = ~clk_s & clk_d_r;
    assign start_ev = clk_s & clk_d_r & dat_d_r & ~dat_s;
    assign stop_ev  = clk_s & clk_d_r & ~dat_d_r & dat_s;

    // ----------------------------------------
    // Register file state
    // ----------------------------------------
    logic [7:0] dir_r, dir_nxt;
    logic [7:0] otype_r, otype_nxt;
    logic [7:0] inten_r, inten_nxt;
    logic [7:0] fancfg_r, fancfg_nxt;
    logic [7:0] data_r, data_nxt;
    logic [2:0] fanspd_r, fanspd_nxt;
    logic [7:0] status_r, status_nxt;
    logic       alert_r, alert_nxt;
    logic [7:0] prev_r, prev_nxt;

    // ----------------------------------------
    // Link engine
    // ----------------------------------------
    link_state_e lk_r, lk_nxt;
    logic [7:0]  sh_r, sh_nxt;
    logic [3:0]  cnt_r, cnt_nxt;
    logic [2:0]  ptr_r, ptr_nxt;
    logic        rd_r, rd_nxt;
    logic        ara_r, ara_nxt;
    logic        drv_r, drv_nxt;
    logic        wr_en;
    logic        rd_clr;
    logic        load;
    logic [7:0]  rd_byte;
    logic [6:0]  own_addr;

    assign own_addr = {`TGT_ADDR_HI, asel_s};

    // Read mux over all seven registers
    always_comb begin
        case (ptr_r)
            `REG_DIR:    rd_byte = dir_r;
            `REG_OTYPE:  rd_byte = otype_r;
            `REG_INTEN:  rd_byte = inten_r;
            `REG_FANCFG: rd_byte = fancfg_r;
            `REG_STATUS: rd_byte = status_r;
            `REG_DATA:   rd_byte = pin_s;
            `REG_FANSPD: rd_byte = {5'h00, fanspd_r};
            default:     rd_byte = 8'h00;
        endcase
    end

    always_comb begin
        lk_nxt  = lk_r;
        sh_nxt  = sh_r;
        cnt_nxt = cnt_r;
        ptr_nxt = ptr_r;
        rd_nxt  = rd_r;
        ara_nxt = ara_r;
        drv_nxt = drv_r;
        wr_en   = 1'b0;
        load    = 1'b0;
        if (start_ev) begin
            lk_nxt  = LK_ADDR;
            cnt_nxt = '0;
            drv_nxt = 1'b0;
        end else if (stop_ev) begin
            lk_nxt  = LK_IDLE;
            drv_nxt = 1'b0;
        end else begin
            case (lk_r)
                LK_ADDR, LK_CMD, LK_WDATA: begin
                    if (clk_rise) begin
                        sh_nxt  = {sh_r[6:0], dat_s};
                        cnt_nxt = cnt_r + 4'h1;
                    end else if (clk_fall && cnt_r == `BYTE_BITS) begin
                        cnt_nxt = '0;
                        drv_nxt = 1'b1;
                        lk_nxt  = LK_ACK_WR;
                        if (lk_r == LK_ADDR) begin
                            rd_nxt  = sh_r[0];
                            ara_nxt = sh_r[7:1] == `ALERT_RESP;
                            lk_nxt  = LK_ACK_ADDR;
                            if (sh_r[7:1] != own_addr &&
                                !(sh_r[7:1] == `ALERT_RESP && sh_r[0] && alert_r)) begin
                                drv_nxt = 1'b0;
                                lk_nxt  = LK_IDLE;
                            end
                        end else if (lk_r == LK_CMD) begin
                            ptr_nxt = sh_r[2:0];
                        end else begin
                            wr_en = 1'b1;
                        end
                    end
                end
                LK_ACK_ADDR: begin
                    if (clk_fall) begin
                        if (rd_r) begin
                            load = 1'b1;
                        end else begin
                            drv_nxt = 1'b0;
                            lk_nxt  = ara_r ? LK_IDLE : LK_CMD;
                        end
                    end
                end
                LK_ACK_WR: begin
                    if (clk_fall) begin
                        drv_nxt = 1'b0;
                        lk_nxt  = LK_WDATA;
                    end
                end
                LK_RDATA: begin
                    if (clk_fall) begin
                        if (cnt_r == `BYTE_BITS) begin
                            drv_nxt = 1'b0;
                            lk_nxt  = LK_RACK;
                        end else begin
                            drv_nxt = ~sh_r[6];
                            sh_nxt  = {sh_r[6:0], 1'b0};
                            cnt_nxt = cnt_r + 4'h1;
                        end
                    end
                end
                LK_RACK: begin
                    if (clk_rise && dat_s) begin
                        lk_nxt = LK_IDLE;
                    end else if (clk_fall) begin
                        load = 1'b1;
                    end
                end
                default: lk_nxt = LK_IDLE;
            endcase
        end
        if (load) begin
            sh_nxt  = ara_r ? {own_addr, 1'b0} : rd_byte;
            drv_nxt = ~sh_nxt[7];
            cnt_nxt = 4'h1;
            lk_nxt  = LK_RDATA;
        end
    end

    // Either clearing read releases the alert
    assign rd_clr = load && (ara_r || ptr_r == `REG_STATUS);

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            lk_r  <= LK_IDLE;
            sh_r  <= '0;
            cnt_r <= '0;
            ptr_r <= '0;
            rd_r  <= 1'b0;
            ara_r <= 1'b0;
            drv_r <= 1'b0;
        end else begin
            lk_r  <= lk_nxt;
            sh_r  <= sh_nxt;
            cnt_r <= cnt_nxt;
            ptr_r <= ptr_nxt;
            rd_r  <= rd_nxt;
            ara_r <= ara_nxt;
            drv_r <= drv_nxt;
        end
    end

    // Open drain only: value pin is held low, the enable does the work
    assign bus_data_out  = 1'b0;
    assign bus_data_oe_n = ~drv_r;

    // ----------------------------------------
    // Register writes
    // ----------------------------------------
    always_comb begin
        dir_nxt    = dir_r;
        otype_nxt  = otype_r;
        inten_nxt  = inten_r;
        fancfg_nxt = fancfg_r;
        data_nxt   = data_r;
        fanspd_nxt = fanspd_r;
        if (wr_en) begin
            case (ptr_r)
                `REG_DIR:    dir_nxt    = sh_r;
                `REG_OTYPE:  otype_nxt  = sh_r;
                `REG_INTEN:  inten_nxt  = sh_r;
                `REG_FANCFG: fancfg_nxt = sh_r;
                `REG_DATA:   data_nxt   = sh_r;
                `REG_FANSPD: fanspd_nxt = sh_r[2:0];
                default:     data_nxt   = data_r;
            endcase
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            dir_r    <= `REG_RST;
            otype_r  <= `REG_RST;
            inten_r  <= `REG_RST;
            fancfg_r <= `REG_RST;
            data_r   <= `REG_RST;
            fanspd_r <= `FANSPD_RST;
        end else begin
            dir_r    <= dir_nxt;
            otype_r  <= otype_nxt;
            inten_r  <= inten_nxt;
            fancfg_r <= fancfg_nxt;
            data_r   <= data_nxt;
            fanspd_r <= fanspd_nxt;
        end
    end

    // ----------------------------------------
    // Change detection and alert
    // ----------------------------------------
    logic [7:0] change;

    // Only enabled input lines report; a line owned by the fan is not masked and reports while its dir_r bit is clear
    assign change = (pin_s ^ prev_r) & inten_r & ~dir_r;

    always_comb begin
        prev_nxt   = pin_s;
        // A change in the clearing cycle survives the clear
        status_nxt = (rd_clr ? 8'h00 : status_r) | change;
        alert_nxt  = alert_r;
        if (|change) begin
            alert_nxt = 1'b1;
        end else if (rd_clr) begin
            alert_nxt = 1'b0;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            prev_r   <= '0;
            status_r <= '0;
            alert_r  <= 1'b0;
        end else begin
            prev_r   <= prev_nxt;
            status_r <= status_nxt;
            alert_r  <= alert_nxt;
        end
    end

    assign alert_out  = 1'b0;
    assign alert_oe_n = ~alert_r;

    // ----------------------------------------
    // Fan control state machine
    // ----------------------------------------
    fan_state_e         fan_r, fan_nxt;
    logic [`TMR_W-1:0]  tmr_r, tmr_nxt;
    logic               fan_en;

    assign fan_en = fancfg_r[`FANCFG_EN_BIT];

    // Spin-up runs full speed first so a stalled fan gets going
    always_comb begin
        fan_nxt = fan_r;
        tmr_nxt = tmr_r;
        case (fan_r)
            FAN_OFF: begin
                if (fan_en && fanspd_r != `FANSPD_RST) begin
                    fan_nxt = FAN_SPINUP;
                    tmr_nxt = `TMR_W'(SPINUP_CYC - 1);
                end
            end
            FAN_SPINUP: begin
                if (!fan_en || fanspd_r == `FANSPD_RST) begin
                    fan_nxt = FAN_OFF;
                end else if (tmr_r == '0) begin
                    fan_nxt = FAN_RUN;
                end else begin
                    tmr_nxt = tmr_r - `TMR_W'(1);
                end
            end
            FAN_RUN: begin
                if (!fan_en || fanspd_r == `FANSPD_RST) begin
                    fan_nxt = FAN_OFF;
                end
            end
            default: fan_nxt = FAN_OFF;
        endcase
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            fan_r <= FAN_OFF;
            tmr_r <= '0;
        end else begin
            fan_r <= fan_nxt;
            tmr_r <= tmr_nxt;
        end
    end

    // ----------------------------------------
    // Parallel line drivers
    // ----------------------------------------
    logic [7:0] out_nxt;
    logic [7:0] oe_n_nxt;
    logic [3:0] fan_pins;

    assign fan_pins[0]   = fan_r != FAN_OFF;
    assign fan_pins[3:1] = fan_r == FAN_SPINUP ? 3'h0 : ~fanspd_r;

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_line
            if (gi >= `UPPER_LO) begin : g_up
                logic v;
                assign v = fan_en ? ~fan_pins[gi-`UPPER_LO] : data_r[gi];
                // Fan outputs are always driven push-pull
                assign out_nxt[gi]  = fan_en ? ~v : data_r[gi];
                assign oe_n_nxt[gi] = fan_en ? 1'b0 :
                                      !dir_r[gi] ? 1'b1 :
                                      otype_r[gi] ? 1'b0 : data_r[gi];
            end else begin : g_lo
                assign out_nxt[gi]  = data_r[gi];
                assign oe_n_nxt[gi] = !dir_r[gi] ? 1'b1 :
                                      otype_r[gi] ? 1'b0 : data_r[gi];
            end
        end
    endgenerate

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            line_out  <= '0;
            line_oe_n <= 8'hff;
        end else begin
            line_out  <= out_nxt;
            line_oe_n <= oe_n_nxt;
        end
    end

endmodule

// ---- testbench/smbus_io_expander_fan_ctl_properties.sv ----
// Port checks for the two-wire I/O expander
`timescale 1ns/10ps
module smbus_io_expander_fan_ctl_properties (
    // Clock and reset
    input wire logic       core_clk,
    input wire logic       rst,
    // Serial link
    input wire logic       bus_clk_in,
    input wire logic       bus_data_in,
    input wire logic       bus_data_out,
    input wire logic       bus_data_oe_n,
    input wire logic [2:0] target_addr_select,
    // Alert and lines
    input wire logic       alert_out,
    input wire logic       alert_oe_n,
    input wire logic [7:0] line_in,
    input wire logic [7:0] line_out,
    input wire logic [7:0] line_oe_n
);
    // ----
    // Cycles since a line moved, saturating
    // ----
    logic [7:0] prev_r, prev_nxt;
    logic [3:0] gap_r, gap_nxt;
    always_comb begin
        prev_nxt = line_in;
        gap_nxt  = (line_in != prev_r) ? 4'h0 : gap_r + {3'h0, gap_r != 4'hf};
    end
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            prev_r <= 8'h00;
            gap_r  <= 4'hf;
        end else begin
            prev_r <= prev_nxt;
            gap_r  <= gap_nxt;
        end
    end
    // ----
    // Properties
    // ----
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    AST_DATA_OPEN_DRAIN: assert property (bus_data_out == 1'b0)
        else $error("data line driven high");
    AST_ALERT_OPEN_DRAIN: assert property (alert_out == 1'b0)
        else $error("alert line driven high");
    // Answers move only in the low phase, else a false start or stop
    AST_ANSWER_IN_LOW: assert property ($changed(bus_data_oe_n) |-> !$past(bus_clk_in, 2))
        else $error("data answer moved near a high clock");
    AST_ANSWER_STANDS: assert property ($fell(bus_data_oe_n) |=> !bus_data_oe_n [*5])
        else $error("data answer too short");
    AST_ALERT_CAUSE: assert property ($fell(alert_oe_n) |-> gap_r <= 4'h8)
        else $error("alert without a line change");
    AST_ALERT_QUIET: assert property (alert_oe_n && gap_r > 4'h8 |=> alert_oe_n)
        else $error("alert raised while lines quiet");
    AST_ALERT_CLEAR: assert property ($rose(alert_oe_n) |-> !bus_clk_in)
        else $error("alert released outside a bus transfer");
    AST_LOWER_OUT_AT_FALL: assert property ($changed(line_out[3:0]) |-> !bus_clk_in)
        else $error("lower line value moved with clock high");
    AST_LOWER_OE_AT_FALL: assert property ($changed(line_oe_n[3:0]) |-> !bus_clk_in)
        else $error("lower line drive moved with clock high");
    COV_ALERT_SET: cover property ($fell(alert_oe_n));
    COV_ALERT_CLR: cover property ($rose(alert_oe_n));
    COV_ACK: cover property ($fell(bus_data_oe_n));
endmodule

bind smbus_io_expander_fan_ctl smbus_io_expander_fan_ctl_properties
    i_smbus_io_expander_fan_ctl_properties (
    .core_clk(core_clk), .rst(rst), .bus_clk_in(bus_clk_in), .bus_data_in(bus_data_in),
    .bus_data_out(bus_data_out), .bus_data_oe_n(bus_data_oe_n),
    .target_addr_select(target_addr_select), .alert_out(alert_out), .alert_oe_n(alert_oe_n),
    .line_in(line_in), .line_out(line_out), .line_oe_n(line_oe_n));

// ---- testbench/smbus_host_model.sv ----
// Two-wire host model; bit period 8 core clocks (160 ns)
`timescale 1ns/10ps
module smbus_host_model (
    // Clock
    input wire logic  core_clk,
    // Serial link
    input wire logic  bus_data_oe_n,
    output logic      bus_clk_in,
    output logic      bus_data_in,
    // Read results
    output logic [7:0] rd_data,
    output logic      rd_stb
);
    logic dat_r = 1'b1;
    logic nak_any;
    initial begin
        bus_clk_in = 1'b1;
        rd_data = 8'h00;
        rd_stb = 1'b0;
    end
    // Pulled-up wire, any party pulling low wins
    assign bus_data_in = dat_r & bus_data_oe_n;
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    // Host alone makes the bit clock, parked high between frames
    task automatic bit_io(input logic b, output logic r);
        tick(3);
        dat_r <= b;
        tick(2);
        bus_clk_in <= 1'b1;
        tick(3);
        r = bus_data_in;
        bus_clk_in <= 1'b0;
    endtask
    // Start is (1,0), stop is (0,1)
    task automatic cond(input logic d0, input logic d1);
        tick(3);
        dat_r <= d0;
        tick(2);
        bus_clk_in <= 1'b1;
        tick(3);
        dat_r <= d1;
        tick(3);
        bus_clk_in <= ~d0;
    endtask
    task automatic tx(input logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r);
        end
        bit_io(1'b1, r);
        nak_any = nak_any | r;
    endtask
    task automatic write_reg(input logic [6:0] a, input logic [2:0] p, input logic [7:0] d,
                             output logic nak);
        nak_any = 1'b0;
        cond(1'b1, 1'b0);
        tx({a, 1'b0});
        tx({5'h00, p});
        tx(d);
        cond(1'b0, 1'b1);
        nak = nak_any;
    endtask
    // Status or alert response read is how the host clears the alert
    task automatic read_reg(input logic [6:0] a, input logic [2:0] p, input logic set_ptr);
        logic [7:0] v;
        logic r;
        if (set_ptr) begin
            cond(1'b1, 1'b0);
            tx({a, 1'b0});
            tx({5'h00, p});
        end
        cond(1'b1, 1'b0);
        tx({a, 1'b1});
        for (int i = 0; i < 8; i++) begin
            bit_io(1'b1, r);
            v = {v[6:0], r};
        end
        bit_io(1'b1, r);
        rd_data <= v;
        rd_stb <= ~rd_stb;
        cond(1'b0, 1'b1);
    endtask
endmodule

// ---- testbench/test_smbus_io_expander_fan_ctl.sv ----
// Self-checking bench for the two-wire I/O expander
`timescale 1ns/10ps
`include "io_expander_regs.svh"
module test_smbus_io_expander_fan_ctl;
    logic        core_clk = 1'b0;
    logic        rst = 1'b1;
    logic [2:0]  target_addr_select = 3'h0;
    logic [7:0]  ext_r = 8'h00;
    logic        bus_clk_in, bus_data_in, bus_data_out, bus_data_oe_n;
    logic        alert_out, alert_oe_n, rd_stb, nak;
    logic [7:0]  line_in, line_out, line_oe_n, rd_data;
    logic [15:0] lfsr_r = 16'hc4ad;
    logic [7:0]  exp_q[$];
    int          n_mismatch = 0;
    int          checks_done = 0;
    always #10 core_clk = ~core_clk;
    // Undriven lines follow the outside world
    assign line_in = (~line_oe_n & line_out) | (line_oe_n & ext_r);
    smbus_io_expander_fan_ctl #(.SPINUP_CYC(20)) i_smbus_io_expander_fan_ctl (
        .core_clk(core_clk), .rst(rst), .bus_clk_in(bus_clk_in), .bus_data_in(bus_data_in),
        .bus_data_out(bus_data_out), .bus_data_oe_n(bus_data_oe_n),
        .target_addr_select(target_addr_select), .alert_out(alert_out),
        .alert_oe_n(alert_oe_n), .line_in(line_in), .line_out(line_out),
        .line_oe_n(line_oe_n));
    smbus_host_model i_smbus_host_model (
        .core_clk(core_clk), .bus_data_oe_n(bus_data_oe_n), .bus_clk_in(bus_clk_in),
        .bus_data_in(bus_data_in), .rd_data(rd_data), .rd_stb(rd_stb));
    // ----
    // Helpers
    // ----
    task automatic chk(input logic [7:0] e, input logic [7:0] a);
        checks_done++;
        if (a !== e) begin
            n_mismatch++;
            $display("wrong value at %0t: expected %h got %h", $time, e, a);
        end
    endtask
    function automatic logic [7:0] rnd();
        lfsr_r = {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
        return lfsr_r[7:0];
    endfunction
    task automatic wr(input logic [2:0] p, input logic [7:0] d);
        i_smbus_host_model.write_reg({`TGT_ADDR_HI, target_addr_select}, p, d, nak);
        chk(8'h00, {7'h00, nak});
    endtask
    task automatic rd(input logic [2:0] p, input logic [7:0] e);
        exp_q.push_back(e);
        i_smbus_host_model.read_reg({`TGT_ADDR_HI, target_addr_select}, p, 1'b1);
    endtask
    task automatic wait_alert(input logic e);
        repeat (12) @(posedge core_clk);
        chk({7'h00, e}, {7'h00, alert_oe_n});
    endtask
    task automatic test_done();
        n_mismatch += exp_q.size();
        $display("mismatches %0d checks %0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // Read results are judged in arrival order
    always @(rd_stb) begin
        if (exp_q.size() > 0) begin
            chk(exp_q.pop_front(), rd_data);
        end
    end
    initial begin
        repeat (60000) @(posedge core_clk);
        n_mismatch++;
        test_done();
    end
    // ----
    // Scenarios
    // ----
    initial begin
        logic [7:0] d, o, x, m, dr;
        repeat (16) @(posedge core_clk);
        rst <= 1'b0;
        repeat (8) @(posedge core_clk);
        chk(8'hff, line_oe_n);
        // Fan bit only, and lower change enables, so no alert can slip in
        for (int p = 0; p < 8; p++) begin
            d = rnd();
            m = (p < 2) ? 8'hff : (p == 2) ? 8'h0f : (p == 3) ? 8'h01 : (p == 6) ? 8'h07 : 8'h00;
            if (p != 5) begin
                wr(p[2:0], d & m);
                rd(p[2:0], d & m);
            end
        end
        wr(`REG_FANCFG, 8'h00);
        wr(`REG_INTEN, 8'h00);
        for (int k = 0; k < 4; k++) begin
            d = rnd();
            o = rnd();
            x = rnd();
            m = rnd();
            ext_r <= x;
            wr(`REG_DIR, d);
            wr(`REG_OTYPE, o);
            wr(`REG_DATA, m);
            dr = d & (o | ~m);
            chk(~dr, line_oe_n);
            chk(d & m, line_out & d);
            rd(`REG_DATA, (dr & m) | (~dr & x));
        end
        wr(`REG_DIR, 8'h00);
        wr(`REG_INTEN, 8'h01);
        ext_r <= ext_r ^ 8'h02;
        wait_alert(1'b1);
        ext_r <= ext_r ^ 8'h01;
        wait_alert(1'b0);
        repeat (40) @(posedge core_clk);
        chk(8'h00, {7'h00, alert_oe_n});
        rd(`REG_STATUS, 8'h01);
        wait_alert(1'b1);
        repeat (30) @(posedge core_clk);
        chk(8'h01, {7'h00, alert_oe_n});
        ext_r <= ext_r ^ 8'h01;
        wait_alert(1'b0);
        exp_q.push_back({`TGT_ADDR_HI, target_addr_select, 1'b0});
        i_smbus_host_model.read_reg(`ALERT_RESP, 3'h0, 1'b0);
        wait_alert(1'b1);
        exp_q.push_back(8'hff);
        i_smbus_host_model.read_reg(`ALERT_RESP, 3'h0, 1'b0);
        for (int s = 0; s < 8; s++) begin
            target_addr_select <= s[2:0];
            repeat (4) @(posedge core_clk);
            rd(`REG_INTEN, 8'h01);
            i_smbus_host_model.write_reg({`TGT_ADDR_HI, s[2:0] ^ 3'h5}, `REG_INTEN, 8'hff, nak);
            chk(8'h01, {7'h00, nak});
        end
        rd(`REG_INTEN, 8'h01);
        wr(`REG_FANCFG, 8'h01);
        for (int s = 0; s < 8; s++) begin
            wr(`REG_FANSPD, s[7:0]);
            @(negedge core_clk);
            if (s == 1) begin
                chk(8'h10, line_out & 8'hf0);
            end
            repeat (30) @(posedge core_clk);
            m = (s == 0) ? 8'h10 : 8'hf0;
            chk(8'h0f, line_oe_n);
            chk({~s[2:0], s != 0, 4'h0} & m, line_out & m);
        end
        test_done();
    end
endmodule
